// ===== verilog/acpc_pkg.sv
`default_nettype none
package acpc_pkg;
   // wishbone word addresses (byte offsets)
   localparam logic [3:0] ADR_CONFIG  = 4'h0;
   localparam logic [3:0] ADR_COMMAND = 4'h4;
   localparam logic [3:0] ADR_STATUS  = 4'h8;
   // command opcodes written to the command register
   localparam logic [7:0] CMD_WAKE  = 8'h02;
   localparam logic [7:0] CMD_SLEEP = 8'h04;
   localparam logic [7:0] CMD_RESET = 8'h06;
   localparam logic [7:0] CMD_START = 8'h08;
   localparam logic [7:0] CMD_STOP  = 8'h0A;
   // timing in converter clock cycles, then the chop divider ratio and the counter widths in bits
   localparam int RST_LOW_MIN   = 4;
   localparam int WAKE_CYCLES   = 512;
   localparam int RESET_SETTLE  = 8;
   localparam int EARLY_WINDOW  = 22;
   localparam int EARLY_CYCLES  = 4;
   localparam int CONV_CYCLES   = 512;
   localparam int CHOP_DIV      = 8;
   localparam int PWRUP_DEFAULT = 65536;
   localparam int WAIT_W        = 17;
   localparam int CONV_W        = 10;

   typedef struct packed {
      logic refBiasEnable;
      logic singleShot;
      logic syncOutEnable;
   } acpc_cfg_t;
   localparam acpc_cfg_t CFG_RESET = 3'h0;
   localparam int CFG_W = 3;

   typedef enum logic [1:0] {
      PWR_RUN   = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_DOWN  = 2'b11
   } acpc_pwr_t;

   typedef enum logic [0:0] {
      CNV_IDLE = 1'b0,
      CNV_RUN  = 1'b1
   } acpc_cnv_t;
endpackage
`default_nettype wire

// ===== verilog/acpc_core.sv
// Notes on behaviour
// RULE1 - sync enable set: chop sync output toggles continuously at clock divided by 8.
// RULE2 - sync enable clear: chop sync output stops and is driven low.
// RULE3 - in power-down the chop sync pin is released and not driven.
// RULE4 - divider phase restarts on any start and on a changing config write.
// RULE5 - sleep command enters low power with all registers kept.
// RULE6 - after wake, 512 cycles pass before ready; host waits for them.
// RULE7 - sleep entry or exit never touches the reference bias enable bit.
// RULE8 - serial timeout function is suspended while asleep.
// RULE9 - reset pin low for at least 4 cycles resets the device.
// RULE10 - reset pin low 2^16 cycles enters power-down, outputs still driven.
// RULE11 - reset pin rising after power-down reloads all register defaults.
// RULE12 - host waits 2^16 cycles after power-down exit before talking.
// RULE13 - reset command restores default configuration and restarts conversion; the code leaves conversion idle until a new start.
// RULE14 - host waits 8 cycles after any reset before talking.
// RULE15 - after power-on, 2^16 cycles are counted before internal reset release.
// RULE16 - start rising begins, falling stops; a new rise restarts a running conversion.
// RULE17 - data ready rises within 4 cycles of start pin rising.
// RULE18 - restart within 22 cycles of data ready fall gives an early discardable fall.
// RULE19 - host keeps start pin low when using start and stop commands.
// RULE20 - single-shot bit 0: conversions repeat until start low or stop.
// RULE21 - stop in gated mode finishes current conversion, flags it, then halts.
// RULE22 - host stops at least 16 cycles before next data ready fall.
// RULE23 - start and stop commands act when the command byte is taken.
// RULE24 - single-shot bit 1: each start does one conversion, flags it, halts.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acpc_core #(
   parameter int PWRUP_CYCLES = acpc_pkg::PWRUP_DEFAULT,
   parameter int PD_CYCLES    = acpc_pkg::PWRUP_DEFAULT
) (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // pins from the host
   input  wire logic        startPin,
   input  wire logic        resetPowerdownPin_n,
   // chop sync pin
   input  wire logic        chopSyncIn,
   output logic             chopSyncOut,
   output logic             chopSyncOe,
   // conversion and power outputs
   output logic             dataReady_n,
   output logic             commReady,
   output logic             serialTimeoutEnable,
   output logic             coreEnable,
   output logic             referenceBiasOut
);
   localparam int WAIT_W = acpc_pkg::WAIT_W;
   localparam int CONV_W = acpc_pkg::CONV_W;
   acpc_pkg::acpc_cfg_t cfg_reg;
   acpc_pkg::acpc_pwr_t pwr_reg;
   acpc_pkg::acpc_cnv_t cnv_reg;
   logic [2:0]  startSync_reg;
   logic        startStable_reg;
   logic [2:0]  rpSync_reg;
   logic        rpStable_reg;
   logic [WAIT_W-1:0] lowCnt_reg;
   logic [WAIT_W-1:0] waitCnt_reg;
   logic [acpc_pkg::CONV_W-1:0] convCnt_reg;
   logic [4:0]  sinceFall_reg;
   logic        gate_reg;
   logic [2:0]  chopDiv_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        chopIn_reg;

   // bus decode
   logic busReq, wrCfg, wrCmd, cmdByteOk, cfgChange;
   logic [7:0] cmd;
   acpc_pkg::acpc_cfg_t cfgWrite;
   assign busReq    = cyc_i && stb_i && !ack_reg;
   assign cmd       = dat_i[7:0];
   assign cfgWrite  = dat_i[acpc_pkg::CFG_W-1:0];
   // the serial side is dead in power-down, so writes are acked and dropped
   assign cmdByteOk = busReq && we_i && sel_i[0] && pwr_reg != acpc_pkg::PWR_DOWN;
   assign wrCfg     = cmdByteOk && adr_i == acpc_pkg::ADR_CONFIG
                      && pwr_reg == acpc_pkg::PWR_RUN;
   assign wrCmd     = cmdByteOk && adr_i == acpc_pkg::ADR_COMMAND;
   assign cfgChange = wrCfg && cfgWrite != cfg_reg;

   logic cmdStart, cmdStop, cmdSleep, cmdWake, cmdReset;
   assign cmdWake  = wrCmd && cmd == acpc_pkg::CMD_WAKE && pwr_reg == acpc_pkg::PWR_SLEEP;
   assign cmdSleep = wrCmd && cmd == acpc_pkg::CMD_SLEEP && pwr_reg == acpc_pkg::PWR_RUN;
   assign cmdReset = wrCmd && cmd == acpc_pkg::CMD_RESET && pwr_reg == acpc_pkg::PWR_RUN;
   assign cmdStart = wrCmd && cmd == acpc_pkg::CMD_START && pwr_reg == acpc_pkg::PWR_RUN; // RULE23
   assign cmdStop  = wrCmd && cmd == acpc_pkg::CMD_STOP && pwr_reg == acpc_pkg::PWR_RUN;  // RULE23

   // pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         startSync_reg   <= 3'h0;
         startStable_reg <= 1'b0;
         rpSync_reg      <= 3'h7;
         rpStable_reg    <= 1'b1;
      end else if (ce) begin
         startSync_reg <= {startSync_reg[1:0], startPin};
         rpSync_reg    <= {rpSync_reg[1:0], resetPowerdownPin_n};
         if (startSync_reg[2] == startSync_reg[1]) begin
            startStable_reg <= startSync_reg[2];
         end
         if (rpSync_reg[2] == rpSync_reg[1]) begin
            rpStable_reg <= rpSync_reg[2];
         end
      end
   end

   logic startRise, startFall, pinReset, enterDown, leaveDown;
   assign startRise = startSync_reg[2] == startSync_reg[1] && startSync_reg[2]
                      && !startStable_reg && pwr_reg == acpc_pkg::PWR_RUN;
   assign startFall = startSync_reg[2] == startSync_reg[1] && !startSync_reg[2]
                      && startStable_reg;
   // short low pulses below the minimum width are ignored
   assign pinReset  = !rpStable_reg && lowCnt_reg == WAIT_W'(acpc_pkg::RST_LOW_MIN - 1);
   assign enterDown = !rpStable_reg && lowCnt_reg == WAIT_W'(PD_CYCLES - 1);
   assign leaveDown = rpStable_reg && pwr_reg == acpc_pkg::PWR_DOWN;

   // wipe restores the configuration, conversion, data ready and divider defaults
   logic wipe;
   assign wipe = pinReset || leaveDown || cmdReset; // RULE9 RULE11 RULE13

   // reset pin low-time counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowCnt_reg <= '0;
      end else if (ce) begin
         if (rpStable_reg) begin
            lowCnt_reg <= '0;
         end else if (lowCnt_reg != WAIT_W'(PD_CYCLES - 1)) begin
            lowCnt_reg <= lowCnt_reg + WAIT_W'(1);
         end
      end
   end

   // power state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_reg <= acpc_pkg::PWR_RUN;
      end else if (ce) begin
         case (pwr_reg)
            acpc_pkg::PWR_RUN: begin
               if (enterDown) begin
                  pwr_reg <= acpc_pkg::PWR_DOWN; // RULE10
               end else if (cmdSleep) begin
                  pwr_reg <= acpc_pkg::PWR_SLEEP; // RULE5
               end
            end
            acpc_pkg::PWR_SLEEP: begin
               if (enterDown) begin
                  pwr_reg <= acpc_pkg::PWR_DOWN;
               end else if (pinReset || cmdWake) begin
                  pwr_reg <= acpc_pkg::PWR_RUN;
               end
            end
            acpc_pkg::PWR_DOWN: begin
               if (leaveDown) begin
                  pwr_reg <= acpc_pkg::PWR_RUN;
               end
            end
            default: pwr_reg <= acpc_pkg::PWR_RUN;
         endcase
      end
   end

   // communication wait counter: power-on, wake, reset and power-down exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitCnt_reg <= WAIT_W'(PWRUP_CYCLES); // RULE15
      end else if (ce) begin
         if (leaveDown) begin
            waitCnt_reg <= WAIT_W'(PD_CYCLES); // RULE12
         end else if (pinReset || cmdReset) begin
            waitCnt_reg <= WAIT_W'(acpc_pkg::RESET_SETTLE); // RULE14
         end else if (cmdWake) begin
            waitCnt_reg <= WAIT_W'(acpc_pkg::WAKE_CYCLES); // RULE6
         end else if (waitCnt_reg != '0 && pwr_reg == acpc_pkg::PWR_RUN) begin
            waitCnt_reg <= waitCnt_reg - WAIT_W'(1);
         end
      end
   end

   // configuration: sleep never touches it, only the wipe sources do
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_reg <= acpc_pkg::CFG_RESET;
      end else if (ce) begin
         if (wipe) begin
            cfg_reg <= acpc_pkg::CFG_RESET;
         end else if (wrCfg) begin
            cfg_reg <= cfgWrite; // RULE7
         end
      end
   end

   // conversion control
   logic convStart, convDone, stopReq, startBlocked;
   assign startBlocked = waitCnt_reg != '0 || rpStable_reg == 1'b0;
   assign convStart = (startRise || cmdStart) && !startBlocked; // RULE16
   assign stopReq   = startFall || cmdStop;
   assign convDone  = cnv_reg == acpc_pkg::CNV_RUN
                      && convCnt_reg == CONV_W'(acpc_pkg::CONV_CYCLES - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnv_reg     <= acpc_pkg::CNV_IDLE;
         convCnt_reg <= '0;
         gate_reg    <= 1'b0;
      end else if (ce) begin
         if (wipe || pwr_reg != acpc_pkg::PWR_RUN) begin
            cnv_reg  <= acpc_pkg::CNV_IDLE;
            gate_reg <= 1'b0;
         end else if (convStart) begin
            cnv_reg  <= acpc_pkg::CNV_RUN; // RULE16
            gate_reg <= !cfg_reg.singleShot;
            // restart close behind a result finishes quickly; that result is junk
            if (sinceFall_reg < 5'(acpc_pkg::EARLY_WINDOW)) begin
               convCnt_reg <= CONV_W'(acpc_pkg::CONV_CYCLES
                                      - acpc_pkg::EARLY_CYCLES); // RULE18
            end else begin
               convCnt_reg <= '0;
            end
         end else begin
            if (stopReq) begin
               gate_reg <= 1'b0; // RULE21
            end
            case (cnv_reg)
               acpc_pkg::CNV_RUN: begin
                  if (convDone) begin
                     convCnt_reg <= '0;
                     if (!gate_reg || stopReq) begin
                        cnv_reg <= acpc_pkg::CNV_IDLE; // RULE24 RULE21
                     end
                  end else begin
                     convCnt_reg <= convCnt_reg + CONV_W'(1); // RULE20
                  end
               end
               acpc_pkg::CNV_IDLE: convCnt_reg <= '0;
               default: cnv_reg <= acpc_pkg::CNV_IDLE;
            endcase
         end
      end
   end

   // data ready and the time since its last fall
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dataReady_n   <= 1'b1;
         sinceFall_reg <= 5'h1F;
      end else if (ce) begin
         if (wipe) begin
            dataReady_n <= 1'b1;
         end else if (convStart) begin
            dataReady_n <= 1'b1; // RULE17
         end else if (convDone) begin
            dataReady_n <= 1'b0;
         end else if (cnv_reg == acpc_pkg::CNV_RUN && convCnt_reg == '0) begin
            dataReady_n <= 1'b1;
         end
         if (convDone) begin
            sinceFall_reg <= '0;
         end else if (sinceFall_reg != 5'h1F) begin
            sinceFall_reg <= sinceFall_reg + 5'h01;
         end
      end
   end

   // chop sync divider
   logic phaseRst;
   assign phaseRst = convStart || cfgChange || wipe; // RULE4
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chopDiv_reg <= 3'h0;
         chopSyncOut <= 1'b0;
      end else if (ce) begin
         if (phaseRst || !cfg_reg.syncOutEnable) begin
            chopDiv_reg <= 3'h0;
            chopSyncOut <= 1'b0; // RULE2
         end else begin
            chopDiv_reg <= chopDiv_reg + 3'h1;
            chopSyncOut <= chopDiv_reg[2] ^ (chopDiv_reg[1:0] == 2'h3); // RULE1
         end
      end
   end
   assign chopSyncOe = pwr_reg != acpc_pkg::PWR_DOWN; // RULE3

   // chop sync pin level read back while released; the pin is asynchronous
   logic [2:0] chopInSync_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chopInSync_reg <= 3'h0;
         chopIn_reg     <= 1'b0;
      end else if (ce) begin
         chopInSync_reg <= {chopInSync_reg[1:0], chopSyncIn};
         if (chopInSync_reg[2] == chopInSync_reg[1]) begin
            chopIn_reg <= chopInSync_reg[2];
         end
      end
   end

   assign commReady           = waitCnt_reg == '0 && pwr_reg == acpc_pkg::PWR_RUN;
   assign serialTimeoutEnable = pwr_reg == acpc_pkg::PWR_RUN; // RULE8
   assign coreEnable          = pwr_reg != acpc_pkg::PWR_DOWN; // RULE10
   assign referenceBiasOut    = cfg_reg.refBiasEnable && pwr_reg != acpc_pkg::PWR_DOWN;

   // wishbone answer: one wait state, unmapped reads give zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0;
      end else if (ce) begin
         ack_reg <= busReq;
         if (busReq && !we_i) begin
            case (adr_i)
               acpc_pkg::ADR_CONFIG: rdata_reg <= {29'h0, cfg_reg};
               acpc_pkg::ADR_STATUS: rdata_reg <= {24'h0, chopIn_reg, gate_reg, cnv_reg,
                                                   dataReady_n, commReady, 1'b0, pwr_reg};
               default:              rdata_reg <= 32'h0;
            endcase
         end
      end
   end
   assign ack_o = ack_reg;
   assign dat_o = rdata_reg;

   // checks
   AST_CHOP_PERIOD: assert property (@(posedge clk) disable iff (rst || !ce)
      $rose(chopSyncOut) && !phaseRst && cfg_reg.syncOutEnable
      ##1 (!phaseRst && cfg_reg.syncOutEnable) [*7]
      |-> ##1 $rose(chopSyncOut))
      else $error("chop sync period not eight"); // RULE1
   AST_CHOP_LOW: assert property (@(posedge clk) disable iff (rst || !ce)
      !cfg_reg.syncOutEnable && pwr_reg != acpc_pkg::PWR_DOWN && !enterDown
      |=> !chopSyncOut && chopSyncOe)
      else $error("chop sync not held low"); // RULE2
   AST_CHOP_RELEASE: assert property (@(posedge clk) disable iff (rst || !ce)
      pwr_reg == acpc_pkg::PWR_DOWN |-> !chopSyncOe)
      else $error("chop sync driven in power-down"); // RULE3
   AST_PHASE_RESET: assert property (@(posedge clk) disable iff (rst || !ce)
      phaseRst |=> chopDiv_reg == 3'h0 && !chopSyncOut)
      else $error("divider phase not reset"); // RULE4
   AST_SLEEP_KEEP: assert property (@(posedge clk) disable iff (rst || !ce)
      pwr_reg == acpc_pkg::PWR_SLEEP && !wipe |=> $stable(cfg_reg))
      else $error("config changed in sleep"); // RULE5 RULE7
   AST_WAKE_WAIT: assert property (@(posedge clk) disable iff (rst || !ce)
      cmdWake |=> !commReady [*8])
      else $error("ready too soon after wake"); // RULE6
   AST_TIMEOUT_OFF: assert property (@(posedge clk) disable iff (rst || !ce)
      pwr_reg == acpc_pkg::PWR_SLEEP |-> !serialTimeoutEnable)
      else $error("serial timeout active in sleep"); // RULE8
   AST_PIN_RESET: assert property (@(posedge clk) disable iff (rst || !ce)
      pinReset |=> cfg_reg == acpc_pkg::CFG_RESET && cnv_reg == acpc_pkg::CNV_IDLE)
      else $error("pin reset had no effect"); // RULE9
   AST_PD_ENTER: assert property (@(posedge clk) disable iff (rst || !ce)
      enterDown |=> pwr_reg == acpc_pkg::PWR_DOWN && !coreEnable)
      else $error("power-down not entered"); // RULE10
   AST_DATA_READY_N_RISE: assert property (@(posedge clk) disable iff (rst || !ce)
      startRise && !startBlocked |=> dataReady_n && cnv_reg == acpc_pkg::CNV_RUN)
      else $error("data ready late after start"); // RULE17
   AST_STOP_FINISH: assert property (@(posedge clk) disable iff (rst || !ce)
      convDone && !gate_reg && !convStart && !wipe
      |=> !dataReady_n && cnv_reg == acpc_pkg::CNV_IDLE)
      else $error("stopped conversion not flagged"); // RULE21 RULE24

   COV_SLEEP_WAKE: cover property (@(posedge clk) disable iff (rst) cmdSleep ##[1:50] cmdWake);
   COV_GATED_TWO: cover property (@(posedge clk) disable iff (rst)
      convDone && gate_reg ##1 cnv_reg == acpc_pkg::CNV_RUN);
   COV_EARLY: cover property (@(posedge clk) disable iff (rst)
      convStart && sinceFall_reg < 5'(acpc_pkg::EARLY_WINDOW));
   COV_PD: cover property (@(posedge clk) disable iff (rst) leaveDown);
endmodule
`default_nettype wire

// ===== bench/acpc_host_side.sv
`timescale 1ns/1ps
`default_nettype none
module acpc_host_side (
   // converter clock
   input  wire logic clk,
   // chop sync pin as driven by the device
   input  wire logic chopSyncOut,
   input  wire logic chopSyncOe,
   // resolved line and measured period in clocks
   output logic      chopLine,
   output int        chopPeriod
);
   logic lastLine;
   int   sinceRise;
   // a released pin is pulled to ground, never left floating
   assign chopLine = chopSyncOe ? chopSyncOut : 1'b0;
   always_ff @(posedge clk) begin
      lastLine <= chopLine;
      sinceRise <= (chopLine && !lastLine) ? 1 : sinceRise + 1;
      if (chopLine && !lastLine) begin
         chopPeriod <= sinceRise;
      end
   end
endmodule
`default_nettype wire

// ===== bench/adc_conversion_power_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_power_control_tb_top;
   localparam int PWR = 64;
   logic        clk, rst, cyc, stb, we, ack, startPin, resetPowerdownPin_n;
   logic        chopSyncOut, chopSyncOe, chopLine, dataReady_n, commReady;
   logic        serialTimeoutEnable, coreEnable, referenceBiasOut;
   logic [3:0]  adr;
   logic [31:0] datI, datO, rd;
   int          chopPeriod, n, n1, err_total, n_checks;

   acpc_core #(.PWRUP_CYCLES(PWR), .PD_CYCLES(PWR)) u_acpc_core (
      .clk(clk), .rst(rst), .ce(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(datI), .dat_o(datO), .ack_o(ack),
      .startPin(startPin), .resetPowerdownPin_n(resetPowerdownPin_n),
      .chopSyncIn(chopLine), .chopSyncOut(chopSyncOut), .chopSyncOe(chopSyncOe),
      .dataReady_n(dataReady_n), .commReady(commReady),
      .serialTimeoutEnable(serialTimeoutEnable), .coreEnable(coreEnable),
      .referenceBiasOut(referenceBiasOut));

   acpc_host_side u_acpc_host_side (
      .clk(clk), .chopSyncOut(chopSyncOut), .chopSyncOe(chopSyncOe),
      .chopLine(chopLine), .chopPeriod(chopPeriod));

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; ack and read data are taken at the same edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      rd = datO;
      chk({31'h0, ack}, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cmd(input logic [7:0] op);
      bus(1'b1, acpc_pkg::ADR_COMMAND, {24'h0, op});
   endtask

   task automatic cfg_is(input logic [2:0] exp);
      bus(1'b0, acpc_pkg::ADR_CONFIG, 32'h0);
      chk({29'h0, rd[2:0]}, {29'h0, exp});
   endtask

   // s selects: 0 data ready, 1 comm ready, 2 chop output
   task automatic wait_on(input int s, input logic v, input int lim);
      logic x;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         x = (s == 0) ? dataReady_n : (s == 1) ? commReady : chopSyncOut;
      end while (x !== v && n < lim);
      chk({31'h0, x}, {31'h0, v});
   endtask

   task automatic count_high(input int s, input int len);
      n = 0;
      repeat (len) begin
         @(posedge clk);
         if (((s == 0) ? dataReady_n : chopSyncOut) !== 1'b0) n++;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole run is about 7k clocks
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      datI = 32'h0;
      startPin = 1'b0;
      resetPowerdownPin_n = 1'b1;
      err_total = 0;
      n_checks = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_on(1, 1'b1, PWR + 20);
      chk({31'h0, n >= PWR && n <= PWR + 6}, 32'h1);
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h1);
      repeat (24) @(posedge clk);
      chk(chopPeriod, 32'h8);
      cmd(acpc_pkg::CMD_START);
      wait_on(2, 1'b1, 20);
      n1 = n;
      repeat (5) @(posedge clk);
      cmd(acpc_pkg::CMD_START);
      chk({31'h0, dataReady_n}, 32'h1);
      wait_on(2, 1'b1, 20);
      chk(n, n1);
      wait_on(0, 1'b0, 600);
      wait_on(0, 1'b1, 3);
      wait_on(0, 1'b0, 600);
      chk({31'h0, n >= 505 && n <= 514}, 32'h1);
      wait_on(0, 1'b1, 3);
      cmd(acpc_pkg::CMD_STOP);
      wait_on(0, 1'b0, 600);
      count_high(0, 600);
      chk(n, 0);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h0);
      count_high(1, 20);
      chk(n, 0);
      chk({31'h0, chopSyncOe}, 32'h1);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h2);
      cmd(acpc_pkg::CMD_START);
      chk({31'h0, dataReady_n}, 32'h1);
      wait_on(0, 1'b0, 600);
      count_high(0, 600);
      chk(n, 0);
      cmd(acpc_pkg::CMD_START);
      wait_on(0, 1'b0, 600);
      cmd(acpc_pkg::CMD_START);
      wait_on(0, 1'b0, 30);
      chk({31'h0, n < 30}, 32'h1);
      repeat (600) @(posedge clk);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h0);
      startPin <= 1'b1;
      wait_on(0, 1'b1, 8);
      // the sampling edge is counted too, so 5 edges span 4 periods
      chk({31'h0, n <= 5}, 32'h1);
      repeat (100) @(posedge clk);
      startPin <= 1'b0;
      repeat (6) @(posedge clk);
      startPin <= 1'b1;
      wait_on(0, 1'b0, 600);
      chk({31'h0, n >= 500}, 32'h1);
      wait_on(0, 1'b1, 3);
      startPin <= 1'b0;
      wait_on(0, 1'b0, 600);
      count_high(0, 600);
      chk(n, 0);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h4);
      cmd(acpc_pkg::CMD_SLEEP);
      bus(1'b0, acpc_pkg::ADR_STATUS, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h1);
      chk({31'h0, serialTimeoutEnable}, 32'h0);
      chk({31'h0, referenceBiasOut}, 32'h1);
      cfg_is(3'h4);
      cmd(acpc_pkg::CMD_WAKE);
      wait_on(1, 1'b1, 600);
      chk({31'h0, n >= 505 && n <= 515}, 32'h1);
      chk({31'h0, referenceBiasOut}, 32'h1);
      chk({31'h0, serialTimeoutEnable}, 32'h1);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h3);
      cmd(acpc_pkg::CMD_RESET);
      wait_on(1, 1'b1, 30);
      cfg_is(3'h0);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h4);
      resetPowerdownPin_n <= 1'b0;
      repeat (5) @(posedge clk);
      resetPowerdownPin_n <= 1'b1;
      repeat (4) @(posedge clk);
      wait_on(1, 1'b1, 40);
      cfg_is(3'h0);
      bus(1'b1, acpc_pkg::ADR_CONFIG, 32'h5);
      resetPowerdownPin_n <= 1'b0;
      repeat (PWR + 12) @(posedge clk);
      chk({31'h0, chopSyncOe}, 32'h0);
      chk({31'h0, chopLine}, 32'h0);
      chk({31'h0, coreEnable}, 32'h0);
      chk({31'h0, dataReady_n === 1'b0 || dataReady_n === 1'b1}, 32'h1);
      resetPowerdownPin_n <= 1'b1;
      repeat (4) @(posedge clk);
      wait_on(1, 1'b1, PWR + 20);
      chk({31'h0, n >= PWR - 4}, 32'h1);
      cfg_is(3'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
